/* File: dv/bus_master_model.sv */
// bus master model: address requests and write beats
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import addr_filter_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // request and beats
    output var addr_req_t o_req,
    output logic o_wvalid,
    output logic o_wlast,
    output logic o_beat_done
);
    initial begin
        o_req = '0;
        o_wvalid = 1'b0;
        o_wlast = 1'b0;
        o_beat_done = 1'b0;
    end
    task automatic request(input logic [39:0] a, input logic ns);
        @(negedge i_core_clk);
        o_req <= '{a, ns, 1'b1};
        @(negedge i_core_clk);
        o_req <= '{~a, ~ns, 1'b0};
    endtask
    task automatic beat(input logic last, input logic done);
        @(negedge i_core_clk);
        o_wvalid <= 1'b1;
        o_wlast <= last;
        o_beat_done <= done;
    endtask
    task automatic idle();
        @(negedge i_core_clk);
        o_wvalid <= 1'b0;
        o_wlast <= 1'b0;
        o_beat_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_address_decode_security_filter.sv */
// testbench: address filter against a behavioural decode model
`timescale 1ns/1ps
`default_nettype none
module tb_address_decode_security_filter;
    import addr_filter_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] sec_open = 4'h0;
    logic sec_we = 1'b0;
    logic [8:0] irq_line = 9'h000;
    logic button = 1'b0;
    addr_req_t req;
    logic wvalid, wlast, beat_done, route_valid, wvalid_fwd, err_beat, irq_pending;
    route_t route;
    logic [8:0] irq_id;
    logic [1:0] sys_err_n, ras_err_n;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int open_mask = 0;
    logic [39:0] addrs[$] = '{40'h00_0000_FFFF, 40'h00_0001_0000, 40'h00_0400_0000,
        40'h00_0403_FFFF, 40'h00_0404_0000, 40'h00_0800_0000, 40'h00_1EFF_FFFF,
        40'h00_1F00_0FFF, 40'h00_1F00_1000, 40'h00_2004_0000, 40'h00_2E00_7FFF,
        40'h00_2E00_8000, 40'h00_4000_0000, 40'h00_8000_0000, 40'h08_7FFF_FFFF,
        40'h0F_FFFF_FFFF, 40'h10_0000_0000};

    always #5 i_core_clk = ~i_core_clk;

    addr_filter #(.PROG_SLOTS(4)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_sec_open(sec_open), .i_sec_cfg_we(sec_we), .i_req(req), .i_wvalid(wvalid),
        .i_wlast(wlast), .i_beat_done(beat_done), .o_route(route),
        .o_route_valid(route_valid), .o_wvalid_fwd(wvalid_fwd), .o_err_beat(err_beat),
        .i_board_irq_line(irq_line), .i_push_button_irq(button), .o_irq_id(irq_id),
        .o_irq_pending(irq_pending), .o_system_error_in_n(sys_err_n),
        .o_ras_error_in_n(ras_err_n));
    bus_master_model mst (.i_core_clk(i_core_clk), .o_req(req), .o_wvalid(wvalid),
        .o_wlast(wlast), .o_beat_done(beat_done));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_route(input route_t got, input route_t exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            end_sim();
        end
    end

    function automatic logic inr(input logic [39:0] a, input logic [39:0] b,
                                 input logic [39:0] s);
        return a >= b && (a - b) < s;
    endfunction
    function automatic route_t exp_route(input logic [39:0] a, input logic ns);
        target_t t;
        logic ok;
        t = TGT_ERR;
        ok = 1'b1;
        if (inr(a, BOOT_ROM_BASE, BOOT_ROM_SIZE) || inr(a, BOOT_RAM_BASE, BOOT_RAM_SIZE)) begin
            t = TGT_BOOT;
            ok = !ns;
        end else if (inr(a, STATIC_MEM_BASE, STATIC_MEM_SIZE)) begin
            t = TGT_STATIC;
        end else if (inr(a, NT_ROM_BASE, NT_ROM_SIZE) || inr(a, SCRATCH_BASE, SCRATCH_SIZE)) begin
            t = TGT_PERIPH;
        end else if (inr(a, PROG_SLOT_BASE, PROG_SLOT_SIZE * 4)) begin
            t = TGT_PERIPH;
            ok = !ns || open_mask[a[17:16]];
        end else if (inr(a, EXP_BASE, EXP_SIZE)) begin
            // expansion target judges prot1 and errors itself
            t = TGT_EXP;
        end else if (inr(a, DRAM_BASE, DRAM_SIZE) || inr(a, DRAM_HI_BASE, DRAM_HI_SIZE)) begin
            t = TGT_DRAM;
        end
        if (t == TGT_ERR || !ok) begin
            return '{TGT_ERR, 1'b1};
        end
        return '{t, 1'b0};
    endfunction

    task automatic xfer(input logic [39:0] a, input logic ns, input int beats);
        route_t e;
        e = exp_route(a, ns);
        mst.request(a, ns);
        chk_route(route, e); // decode result
        chk_sig(9'(route_valid), 9'h001); // route held
        for (int i = 0; i <= beats; i++) begin
            mst.beat(i == beats, i != 0);
            #1 chk_sig(9'({wvalid_fwd, err_beat}), 9'({~e.decerr, e.decerr && i != 0}));
        end
        mst.idle();
        #1 chk_sig(9'(route_valid), 9'h000); // burst closed
    endtask

    initial begin
        logic [39:0] a;
        logic [3:0] m;
        void'($urandom(32'hb4f7d8d7));
        repeat (16) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        chk_sig(9'(route_valid), 9'h000); // idle after reset
        chk_sig(9'(sys_err_n), 9'h003); // tied high
        chk_sig(9'(ras_err_n), 9'h003); // tied high
        $display("test reset done");
        foreach (addrs[i]) begin
            xfer(addrs[i], 1'b0, 2); // secure map
            xfer(addrs[i], 1'b1, 2); // non-secure map
        end
        $display("test map done");
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 4'h5 : (k == 1) ? 4'hA : 4'($urandom);
            @(negedge i_core_clk);
            sec_open = m;
            sec_we = 1'b1;
            @(negedge i_core_clk);
            sec_we = 1'b0;
            sec_open = ~m;
            open_mask = m;
            for (int n = 0; n < 4; n++) begin
                xfer(PROG_SLOT_BASE + 40'(n * 65536 + $urandom_range(65535)), 1'b1, 1);
            end
        end
        $display("test config done");
        @(negedge i_core_clk);
        i_sys_rst = 1'b1;
        @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        open_mask = 0;
        for (int n = 0; n < 4; n++) begin
            xfer(PROG_SLOT_BASE + 40'(n * 65536), 1'b1, 1); // secure only again
            xfer(PROG_SLOT_BASE + 40'(n * 65536), 1'b0, 1); // secure passes
        end
        $display("test rerun done");
        repeat (60) begin
            a = {8'($urandom_range(16)), 32'($urandom)};
            xfer(a, 1'($urandom), $urandom_range(3, 1)); // random addresses
        end
        $display("test random done");
        for (int k = 0; k < 9; k++) begin
            @(negedge i_core_clk);
            irq_line = 9'h100 | 9'(1 << k);
            button = 1'b1;
            repeat (3) @(posedge i_core_clk);
            #1 chk_sig(irq_id, 9'h0C0 + 9'(k)); // lowest line
            repeat (4) @(posedge i_core_clk);
            #1 chk_sig(irq_id, 9'h0C0 + 9'(k)); // level held
            chk_sig(9'(irq_pending), 9'h001); // pending
        end
        @(negedge i_core_clk);
        irq_line = 9'h000;
        repeat (3) @(posedge i_core_clk);
        #1 chk_sig(irq_id, 9'h0C9); // button
        @(negedge i_core_clk);
        button = 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1 chk_sig(irq_id, 9'h000); // released
        $display("test irq done");
        end_sim();
    end
endmodule
`default_nettype wire

/* File: include/addr_filter_pkg.sv */
// package: address map, security attributes, interrupt numbering for the address filter
package addr_filter_pkg;
    // ****************************************
    // address map
    // ****************************************
    localparam int ADDR_W = 40;
    localparam logic [39:0] BOOT_ROM_BASE = 40'h00_0000_0000;
    localparam logic [39:0] BOOT_ROM_SIZE = 40'h00_0001_0000;
    localparam logic [39:0] BOOT_RAM_BASE = 40'h00_0400_0000;
    localparam logic [39:0] BOOT_RAM_SIZE = 40'h00_0004_0000;
    localparam logic [39:0] BOOT_REGION_SIZE = 40'h00_0800_0000;
    localparam logic [39:0] STATIC_MEM_BASE = 40'h00_0800_0000;
    localparam logic [39:0] STATIC_MEM_SIZE = 40'h00_1700_0000;
    localparam logic [39:0] PERIPH_BASE = 40'h00_1F00_0000;
    localparam logic [39:0] PERIPH_SIZE = 40'h00_1000_0000;
    localparam logic [39:0] NT_ROM_BASE = 40'h00_1F00_0000;
    localparam logic [39:0] NT_ROM_SIZE = 40'h00_0000_1000;
    localparam logic [39:0] SCRATCH_BASE = 40'h00_2E00_0000;
    localparam logic [39:0] SCRATCH_SIZE = 40'h00_0000_8000;
    localparam logic [39:0] PROG_SLOT_BASE = 40'h00_2000_0000;
    localparam logic [39:0] PROG_SLOT_SIZE = 40'h00_0001_0000;
    localparam logic [39:0] EXP_BASE = 40'h00_4000_0000;
    localparam logic [39:0] EXP_SIZE = 40'h00_4000_0000;
    localparam logic [39:0] DRAM_BASE = 40'h00_8000_0000;
    localparam logic [39:0] DRAM_SIZE = 40'h00_8000_0000;
    localparam logic [39:0] DRAM_HI_BASE = 40'h08_8000_0000;
    localparam logic [39:0] DRAM_HI_SIZE = 40'h07_8000_0000;
    // ****************************************
    // interrupts and responses
    // ****************************************
    localparam int BOARD_IRQ_N = 9;
    localparam logic [8:0] BOARD_IRQ_ID_BASE = 9'h0C0;
    localparam logic [8:0] PUSH_BUTTON_IRQ_ID = 9'h0C9;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int SEC_CFG_W = 4;
    localparam logic [3:0] SEC_CFG_RESET = 4'h0;

    typedef enum logic [2:0] {
        TGT_ERR = 3'h0,
        TGT_BOOT = 3'h1,
        TGT_STATIC = 3'h2,
        TGT_PERIPH = 3'h3,
        TGT_EXP = 3'h4,
        TGT_DRAM = 3'h5
    } target_t;

    typedef struct packed {
        logic [39:0] addr;
        logic prot1;
        logic valid;
    } addr_req_t;

    typedef struct packed {
        target_t target;
        logic decerr;
    } route_t;
endpackage

/* File: rtl/addr_filter.sv */
// address decoder and security filter for the application address space
//
// Summary of operation
// - board interrupts are taken as levels, no edge detection
// - board lines 3..11 become ids 192..200, push button 201
// - both cluster system error inputs are tied high
// - addresses are 40 bits wide, 1024GB space
// - reserved areas answer decode error, reach no target
// - secure-only regions reject non-secure with decode error
// - programmable regions switch secure/open, reset to secure-only
// - unused part of a peripheral slot answers decode error
// - occupied ranges are forwarded, target decides response
// - lowest 128MB boot region is secure-only
// - boot region holds 64KB trusted rom, 256KB trusted ram
// - 368MB static memory window from 0x0800_0000
// - 256MB peripheral window from 0x1F00_0000
// - peripheral area holds a 32KB open scratch sram
// - expansion areas route to the expansion interface
// - dram areas route to the dynamic memory controller
// - security configuration resets to zero
`timescale 1ns/1ps
`default_nettype none
module addr_filter
    import addr_filter_pkg::*;
#(
    parameter int PROG_SLOTS = SEC_CFG_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // trusted security configuration
    input wire logic [PROG_SLOTS-1:0] i_sec_open,
    input wire logic i_sec_cfg_we,
    // request
    input wire addr_req_t i_req,
    input wire logic i_wvalid,
    input wire logic i_wlast,
    input wire logic i_beat_done,
    // routing result
    output route_t o_route,
    output logic o_route_valid,
    output logic o_wvalid_fwd,
    output logic o_err_beat,
    // interrupts
    input wire logic [BOARD_IRQ_N-1:0] i_board_irq_line,
    input wire logic i_push_button_irq,
    output logic [8:0] o_irq_id,
    output logic o_irq_pending,
    output logic [1:0] o_system_error_in_n,
    output logic [1:0] o_ras_error_in_n
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic in_win(input logic [39:0] a, input logic [39:0] b,
                                    input logic [39:0] s);
        in_win = (a >= b) && ((a - b) < s);
    endfunction

    logic [BOARD_IRQ_N-1:0] line_s0_reg, line_s1_reg;
    logic pb_s0_reg, pb_s1_reg;
    logic [PROG_SLOTS-1:0] sec_open_reg;
    route_t route_reg, route_next;
    logic route_valid_reg;
    logic [8:0] irq_id_reg, irq_id_next;
    logic irq_pending_reg;
    logic [1:0] prog_idx;

    // ****************************************
    // tie-offs
    // ****************************************
    // error inputs unused
    assign o_system_error_in_n = 2'b11;
    assign o_ras_error_in_n = 2'b11;

    // ****************************************
    // security configuration
    // ****************************************
    // reset secure-only
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sec_open_reg <= PROG_SLOTS'(SEC_CFG_RESET);
        end else if (i_sec_cfg_we) begin
            sec_open_reg <= i_sec_open;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    assign prog_idx = i_req.addr[17:16];
    always_comb begin
        route_next.target = TGT_ERR;
        route_next.decerr = 1'b1;
        if (in_win(i_req.addr, BOOT_ROM_BASE, BOOT_REGION_SIZE)) begin
            if (in_win(i_req.addr, BOOT_ROM_BASE, BOOT_ROM_SIZE) ||
                in_win(i_req.addr, BOOT_RAM_BASE, BOOT_RAM_SIZE)) begin
                if (!i_req.prot1) begin
                    route_next.target = TGT_BOOT;
                    route_next.decerr = 1'b0;
                end
            end
        end else if (in_win(i_req.addr, STATIC_MEM_BASE, STATIC_MEM_SIZE)) begin
            route_next.target = TGT_STATIC;
            route_next.decerr = 1'b0;
        end else if (in_win(i_req.addr, PERIPH_BASE, PERIPH_SIZE)) begin
            if (in_win(i_req.addr, NT_ROM_BASE, NT_ROM_SIZE) ||
                in_win(i_req.addr, SCRATCH_BASE, SCRATCH_SIZE)) begin
                route_next.target = TGT_PERIPH;
                route_next.decerr = 1'b0;
            end else if (in_win(i_req.addr, PROG_SLOT_BASE,
                                PROG_SLOT_SIZE * PROG_SLOTS)) begin
                if (!i_req.prot1 || sec_open_reg[prog_idx]) begin
                    route_next.target = TGT_PERIPH;
                    route_next.decerr = 1'b0;
                end
            end
        end else if (in_win(i_req.addr, EXP_BASE, EXP_SIZE)) begin
            route_next.target = TGT_EXP;
            route_next.decerr = 1'b0;
        end else if (in_win(i_req.addr, DRAM_BASE, DRAM_SIZE) ||
                     in_win(i_req.addr, DRAM_HI_BASE, DRAM_HI_SIZE)) begin
            route_next.target = TGT_DRAM;
            route_next.decerr = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            route_reg <= '{target: TGT_ERR, decerr: 1'b0};
            route_valid_reg <= 1'b0;
        end else if (i_req.valid) begin
            route_reg <= route_next;
            route_valid_reg <= 1'b1;
        end else if (i_beat_done && i_wlast) begin
            route_valid_reg <= 1'b0;
        end
    end

    assign o_route = route_reg;
    assign o_route_valid = route_valid_reg;
    // block write data, error each beat with i_beat_done
    assign o_wvalid_fwd = i_wvalid && route_valid_reg && !route_reg.decerr;
    assign o_err_beat = route_valid_reg && route_reg.decerr && i_beat_done;

    // ****************************************
    // board interrupts
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            line_s0_reg <= '0;
            line_s1_reg <= '0;
            pb_s0_reg <= 1'b0;
            pb_s1_reg <= 1'b0;
        end else begin
            line_s0_reg <= i_board_irq_line;
            line_s1_reg <= line_s0_reg;
            pb_s0_reg <= i_push_button_irq;
            pb_s1_reg <= pb_s0_reg;
        end
    end

    always_comb begin
        irq_id_next = '0;
        if (pb_s1_reg) begin
            irq_id_next = PUSH_BUTTON_IRQ_ID;
        end
        for (int k = BOARD_IRQ_N - 1; k >= 0; k--) begin
            if (line_s1_reg[k]) begin
                irq_id_next = BOARD_IRQ_ID_BASE + 9'(k);
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_id_reg <= '0;
            irq_pending_reg <= 1'b0;
        end else begin
            irq_id_reg <= irq_id_next;
            irq_pending_reg <= (|line_s1_reg) || pb_s1_reg;
        end
    end
    assign o_irq_id = irq_id_reg;
    assign o_irq_pending = irq_pending_reg;

    // ****************************************
    // checks
    // ****************************************
    property p_boot_secure;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && i_req.prot1 && (i_req.addr < BOOT_REGION_SIZE)
        |=> route_reg.decerr;
    endproperty
    a_boot_secure: assert property (p_boot_secure) else $error("boot open");

    property p_static;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && in_win(i_req.addr, STATIC_MEM_BASE, STATIC_MEM_SIZE)
        |=> route_reg.target == TGT_STATIC && !route_reg.decerr;
    endproperty
    a_static: assert property (p_static) else $error("static miss");

    property p_dram;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && in_win(i_req.addr, DRAM_BASE, DRAM_SIZE)
        |=> route_reg.target == TGT_DRAM;
    endproperty
    a_dram: assert property (p_dram) else $error("dram miss");

    property p_exp;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && in_win(i_req.addr, EXP_BASE, EXP_SIZE)
        |=> route_reg.target == TGT_EXP;
    endproperty
    a_exp: assert property (p_exp) else $error("exp miss");

    property p_no_wdata;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && i_req.prot1 && (i_req.addr < BOOT_REGION_SIZE)
        ##1 !i_req.valid ##1 i_wvalid |-> !o_wvalid_fwd;
    endproperty
    a_no_wdata: assert property (p_no_wdata) else $error("wdata leak");

    property p_prog_reset;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(route_valid_reg) && !$past(i_sec_cfg_we, 3) && $past(sec_open_reg) == '0
        && route_reg.target == TGT_PERIPH |-> !$past(i_req.prot1) || !$past(
        in_win(i_req.addr, PROG_SLOT_BASE, PROG_SLOT_SIZE));
    endproperty
    a_prog_reset: assert property (p_prog_reset) else $error("prog open");

    property p_tie;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_system_error_in_n == 2'b11 && o_ras_error_in_n == 2'b11;
    endproperty
    a_tie: assert property (p_tie) else $error("tie lost");

    property p_irq_id;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_board_irq_line[0] [*3] |=> o_irq_id == BOARD_IRQ_ID_BASE;
    endproperty
    a_irq_id: assert property (p_irq_id) else $error("irq id");

    property p_reserved;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && i_req.addr >= (DRAM_HI_BASE + DRAM_HI_SIZE) |=> route_reg.decerr;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved hit");

    property p_scratch;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && in_win(i_req.addr, SCRATCH_BASE, SCRATCH_SIZE)
        |=> route_reg.target == TGT_PERIPH && !route_reg.decerr;
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch miss");

    property p_prog_open;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && !i_req.prot1 &&
        in_win(i_req.addr, PROG_SLOT_BASE, PROG_SLOT_SIZE * PROG_SLOTS)
        |=> route_reg.target == TGT_PERIPH && !route_reg.decerr;
    endproperty
    a_prog_open: assert property (p_prog_open) else $error("secure refused");

    property p_dram_hi;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_req.valid && in_win(i_req.addr, DRAM_HI_BASE, DRAM_HI_SIZE)
        |=> route_reg.target == TGT_DRAM && !route_reg.decerr;
    endproperty
    a_dram_hi: assert property (p_dram_hi) else $error("dram high miss");

    property p_irq_pb;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_push_button_irq && i_board_irq_line == '0) [*3] |=> o_irq_id == PUSH_BUTTON_IRQ_ID;
    endproperty
    a_irq_pb: assert property (p_irq_pb) else $error("button id");

    property p_irq_idle;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_board_irq_line == '0 && !i_push_button_irq) [*3] |=> !o_irq_pending;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq stuck");

    c_err: cover property (@(posedge i_core_clk) o_err_beat);
    c_boot: cover property (@(posedge i_core_clk) route_reg.target == TGT_BOOT);
    c_prog_open: cover property (@(posedge i_core_clk) o_wvalid_fwd && sec_open_reg != '0);
    c_dram: cover property (@(posedge i_core_clk) route_reg.target == TGT_DRAM);
    c_pb: cover property (@(posedge i_core_clk) o_irq_id == PUSH_BUTTON_IRQ_ID);
endmodule
`default_nettype wire
